// [bench/sie_far_model.sv]
// Far-side model: exception, pending, event and debug sources
`timescale 1ns/1ps
`default_nettype none
module sie_far_model
(
  input  wire logic       ref_clk,
  input  wire logic       fire,
  input  wire logic [1:0] sel,
  input  wire logic [3:0] dly,
  output logic            exc_take,
  output logic            exc_pend_new,
  output logic            ext_event_pin,
  output logic            dbg_req_pin
);
  initial {exc_take, exc_pend_new, ext_event_pin, dbg_req_pin} = 4'h0;
  // Raise one source after a delay, off the edge, then release it
  always
  begin
    @(posedge ref_clk iff fire);
    repeat (dly) @(posedge ref_clk);
    #37;
    case (sel)
      2'h0: exc_take = 1'b1;
      2'h1: exc_pend_new = 1'b1;
      2'h2: ext_event_pin = 1'b1;
      default: dbg_req_pin = 1'b1;
    endcase
    // Pending news is a single-cycle pulse, the rest are held levels
    repeat ((sel == 2'h1) ? 1 : 6) @(posedge ref_clk);
    #37;
    {exc_take, exc_pend_new, ext_event_pin, dbg_req_pin} = 4'h0;
  end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench of the system instruction executor
`include "sie_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
  logic               ref_clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               op_valid = 1'b0;
  logic               privileged = 1'b1;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               fire = 1'b0;
  logic [1:0]         sel = 2'h0;
  logic [3:0]         dly = 4'h0;
  logic [3:0]         reg_addr = 4'h0;
  logic [8:0]         ipsr_val = 9'h000;
  logic [31:0]        src_val = 32'h0;
  logic [31:0]        reg_wdata = 32'h0;
  sie_pkg::sie_op_t   op_kind = sie_pkg::SIE_NO_OP;
  sie_pkg::sie_spec_t spec_sel = sie_pkg::SIE_APP_SW;
  logic               exc_take, exc_pend_new, ext_event_pin, dbg_req_pin;
  logic               irq, op_done, op_busy, pipe_flush, call_exc, send_ev_out;
  logic               glb_mask_out, flt_mask_out, event_reg_out;
  logic [1:0]         control_out;
  logic [4:0]         flags_out;
  logic [4:0]         fexp;
  logic [7:0]         pri_thr_out;
  logic [7:0]         c;
  logic [7:0]         s;
  logic [31:0]        reg_rdata, rd_spec_data, v;
  int                 n_mismatch = 0;
  int                 checks = 0;

  // Core clock, 100 ns period
  always #50 ref_clk = ~ref_clk;

  sie_exec dut_u (.ref_clk, .arst_n, .op_valid, .op_kind, .spec_sel, .src_val, .privileged,
    .ipsr_val, .exc_take, .exc_pend_new, .ext_event_pin, .dbg_req_pin, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .op_done, .op_busy, .pipe_flush, .call_exc,
    .send_ev_out, .rd_spec_data, .flags_out, .pri_thr_out, .glb_mask_out, .flt_mask_out,
    .control_out, .event_reg_out);

  sie_far_model far_u (.ref_clk, .fire, .sel, .dly, .exc_take, .exc_pend_new, .ext_event_pin,
    .dbg_req_pin);

  // Verdict and end of run
  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Issue one instruction; returns in the cycle after it is taken
  task automatic op(input sie_pkg::sie_op_t k, input sie_pkg::sie_spec_t sp = sie_pkg::SIE_APP_SW,
                    input logic [31:0] d = 32'h0, input logic p = 1'b1);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    spec_sel <= sp;
    src_val <= d;
    privileged <= p;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  // Start one far-side source with a random delay
  task automatic kick(input logic [1:0] k);
    @(posedge ref_clk);
    fire <= 1'b1;
    sel <= k;
    dly <= 4'($urandom_range(0, 9));
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 40 && op_done !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (op_done !== 1'b1)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask

  // Threshold expected after a conditional raise
  function automatic logic [7:0] raise_exp(input logic [7:0] cur, input logic [7:0] src);
    return (src != 8'h00 && (cur == 8'h00 || src < cur)) ? src : cur;
  endfunction

  initial
  begin
    void'($urandom(43656));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    `CHK("pri_thr", 8'h00, pri_thr_out)
    `CHK("event_reg", 1'b0, event_reg_out)
    op(sie_pkg::SIE_SYNC_BAR);
    `CHK("pipe_flush", 1'b1, pipe_flush)
    v = $urandom;
    op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_APP_SW, v, 1'b0);
    `CHK("flags", v[31:27], flags_out)
    ipsr_val <= 9'($urandom);
    op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_ALL_SW, 32'hffffffff, 1'b0);
    op(sie_pkg::SIE_RD_SPEC, sie_pkg::SIE_ALL_SW);
    `CHK("all_sw", {5'h1f, 18'h0, ipsr_val}, rd_spec_data)
    fexp = 5'h1f;
    c = 8'($urandom_range(1, 255));
    op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_PRI_THR, {24'h0, c});
    op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_CONTROL, 32'h3);
    op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_GLB_MASK, 32'h1);
    op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_PRI_THR, 32'h0, 1'b0);
    op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_CONTROL, 32'h0, 1'b0);
    op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_FLT_MASK, 32'h1, 1'b0);
    `CHK("pri_thr", c, pri_thr_out)
    `CHK("control", 2'h3, control_out)
    `CHK("glb_mask", 1'b1, glb_mask_out)
    `CHK("flt_mask", 1'b0, flt_mask_out)
    op(sie_pkg::SIE_RD_SPEC, sie_pkg::SIE_GLB_MASK);
    `CHK("rd_mask", 32'h1, rd_spec_data)
    op(sie_pkg::SIE_RD_SPEC, sie_pkg::SIE_PRI_RAISE);
    `CHK("rd_raise", {24'h0, c}, rd_spec_data)
    // Raise alias: zero current, zero source, equal and random values
    for (int i = 0; i < 24; i++)
    begin
      c = (i % 4 == 0) ? 8'h00 : 8'($urandom);
      s = (i % 4 == 1) ? 8'h00 : (i % 4 == 2) ? c : 8'($urandom);
      op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_PRI_THR, {24'h0, c});
      op(sie_pkg::SIE_WR_SPEC, sie_pkg::SIE_PRI_RAISE, {24'h0, s});
      `CHK("raise", raise_exp(c, s), pri_thr_out)
    end
    op(sie_pkg::SIE_NO_OP);
    `CHK("no_op_done", 1'b1, op_done)
    op(sie_pkg::SIE_SEND_EV);
    `CHK("send_ev_out", 1'b1, send_ev_out)
    `CHK("event_reg", 1'b1, event_reg_out)
    op(sie_pkg::SIE_SUP_CALL, sie_pkg::SIE_APP_SW, $urandom);
    `CHK("call_exc", 1'b1, call_exc)
    op(sie_pkg::SIE_WAIT_EV);
    `CHK("wfe_done", 1'b1, op_done)
    `CHK("event_reg", 1'b0, event_reg_out)
    `CHK("flags", fexp, flags_out)
    // Wake sources; the last pass has pending news without its enable
    wr(`SIE_OFF_CTRL, 32'h3);
    for (int k = 0; k < 5; k++)
    begin
      if (k == 4)
        wr(`SIE_OFF_CTRL, 32'h0);
      op(sie_pkg::SIE_WAIT_EV);
      `CHK("wfe_busy", 1'b1, op_busy)
      kick((k == 4) ? 2'h1 : 2'(k));
      if (k == 4)
      begin
        repeat (20) @(posedge ref_clk);
        #1;
        `CHK("no_wake", 1'b1, op_busy)
        kick(2'h0);
      end
      wait_done();
      `CHK("woken", 1'b0, op_busy)
      `CHK("event_reg", 1'b0, event_reg_out)
      repeat (12) @(posedge ref_clk);
    end
    kick(2'h2);
    repeat (16) @(posedge ref_clk);
    #1;
    `CHK("ext_event", 1'b1, event_reg_out)
    op(sie_pkg::SIE_WAIT_INT);
    `CHK("wfi_busy", 1'b1, op_busy)
    kick(2'h3);
    wait_done();
    `CHK("wfi_wake", 1'b0, op_busy)
    `CHK("flags", fexp, flags_out)
    // Status, mask, clear and an unmapped place
    rdchk(`SIE_OFF_STAT, 32'hf);
    `CHK("irq", 1'b0, irq)
    wr(`SIE_OFF_MASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("irq", 1'b1, irq)
    wr(`SIE_OFF_STAT, 32'h2);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("irq", 1'b0, irq)
    rdchk(`SIE_OFF_STAT, 32'hd);
    rdchk(`SIE_OFF_MASK, 32'h2);
    rdchk(`SIE_OFF_CTRL, 32'h4);
    rdchk(4'hc, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire

// [src/sie_exec.sv]
// Executor for barrier, special moves, hints, supervisor call and sleep hints
`include "sie_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sie_exec
#(
  parameter int PRIO_W = 8
)
(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              op_valid,
  input  wire sie_pkg::sie_op_t  op_kind,
  input  wire sie_pkg::sie_spec_t spec_sel,
  input  wire logic [31:0]       src_val,
  input  wire logic              privileged,
  input  wire logic [8:0]        ipsr_val,
  input  wire logic              exc_take,
  input  wire logic              exc_pend_new,
  input  wire logic              ext_event_pin,
  input  wire logic              dbg_req_pin,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   irq,
  output logic                   op_done,
  output logic                   op_busy,
  output logic                   pipe_flush,
  output logic                   call_exc,
  output logic                   send_ev_out,
  output logic [31:0]            rd_spec_data,
  output logic [4:0]             flags_out,
  output logic [PRIO_W-1:0]      pri_thr_out,
  output logic                   glb_mask_out,
  output logic                   flt_mask_out,
  output logic [1:0]             control_out,
  output logic                   event_reg_out
);
  sie_pkg::sie_state_t s_q;
  sie_pkg::sie_state_t s_d;
  logic                iss;
  logic                ext_ev;
  logic                wake_ev;
  logic                wake_int;
  logic                app_ok;
  logic [4:0]          ev_set;
  logic [PRIO_W-1:0]   src_pri;
  logic [PRIO_W-1:0]   cur_pri;
  logic [31:0]         app_v;
  logic [31:0]         ipsr_v;

  // ==========================================================================
  // Decode and wake terms
  // ==========================================================================
  assign iss      = op_valid && (s_q.slp == sie_pkg::SIE_RUN);
  assign ext_ev   = s_q.ext_s2 && !s_q.ext_s3;
  assign src_pri  = src_val[PRIO_W-1:0];
  assign cur_pri  = s_q.pri_thr[PRIO_W-1:0];
  assign app_v    = {s_q.flags, 27'h0000000};
  assign ipsr_v   = {23'h000000, ipsr_val};
  // Wake for the event wait
  assign wake_ev  = exc_take || (exc_pend_new && s_q.pend_wake) ||
                    (s_q.dbg_s2 && s_q.dbg_en) || ext_ev;
  // Wake for the interrupt wait, debug enable not consulted
  assign wake_int = exc_take || exc_pend_new || s_q.dbg_s2;
  // Selectors whose writes carry the flags
  assign app_ok   = (spec_sel == sie_pkg::SIE_APP_SW) || (spec_sel == sie_pkg::SIE_IAPSR) ||
                    (spec_sel == sie_pkg::SIE_EAPSR) || (spec_sel == sie_pkg::SIE_ALL_SW);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    s_d        = s_q;
    ev_set     = 5'h00;
    s_d.ext_s1 = ext_event_pin;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    s_d.dbg_s1 = dbg_req_pin;
    s_d.dbg_s2 = s_q.dbg_s1;
    s_d.done   = 1'b0;
    s_d.flush  = 1'b0;
    s_d.call   = 1'b0;
    s_d.sevo   = 1'b0;
    // Instruction execution
    if (iss)
    begin
      unique case (op_kind)
        sie_pkg::SIE_SYNC_BAR:
        begin
          s_d.flush = 1'b1;
          s_d.done  = 1'b1;
          ev_set[`SIE_ST_FLUSH] = 1'b1;
        end
        sie_pkg::SIE_RD_SPEC:
        begin
          s_d.done = 1'b1;
          unique case (spec_sel)
            sie_pkg::SIE_APP_SW, sie_pkg::SIE_EAPSR: s_d.rd_val = app_v;
            sie_pkg::SIE_IPSR, sie_pkg::SIE_IEPSR:   s_d.rd_val = ipsr_v;
            sie_pkg::SIE_IAPSR, sie_pkg::SIE_ALL_SW: s_d.rd_val = app_v | ipsr_v;
            sie_pkg::SIE_GLB_MASK: s_d.rd_val = {31'h00000000, s_q.glb_mask};
            sie_pkg::SIE_FLT_MASK: s_d.rd_val = {31'h00000000, s_q.flt_mask};
            sie_pkg::SIE_CONTROL:  s_d.rd_val = {30'h00000000, s_q.control};
            sie_pkg::SIE_PRI_THR, sie_pkg::SIE_PRI_RAISE:
              s_d.rd_val = {24'h000000, s_q.pri_thr};
            default: s_d.rd_val = 32'h00000000; // Stack pointers live in the register bank
          endcase
        end
        sie_pkg::SIE_WR_SPEC:
        begin
          s_d.done = 1'b1;
          // Only flags are reachable without privilege, state bits dropped
          if (app_ok)
            s_d.flags = src_val[31:`SIE_FLAG_LSB];
          if (privileged)
          begin
            unique case (spec_sel)
              sie_pkg::SIE_GLB_MASK: s_d.glb_mask = src_val[0];
              sie_pkg::SIE_FLT_MASK: s_d.flt_mask = src_val[0];
              sie_pkg::SIE_CONTROL:  s_d.control  = src_val[1:0];
              sie_pkg::SIE_PRI_THR:  s_d.pri_thr[PRIO_W-1:0] = src_pri;
              sie_pkg::SIE_PRI_RAISE:
                if ((src_pri != '0) && ((cur_pri == '0) || (src_pri < cur_pri)))
                  s_d.pri_thr[PRIO_W-1:0] = src_pri;
              default: s_d.done = 1'b1;
            endcase
          end
        end
        sie_pkg::SIE_NO_OP: s_d.done = 1'b1;
        sie_pkg::SIE_SEND_EV:
        begin
          s_d.sevo = 1'b1;
          s_d.done = 1'b1;
          ev_set[`SIE_ST_SEND] = 1'b1;
        end
        sie_pkg::SIE_SUP_CALL:
        begin
          s_d.call = 1'b1;
          s_d.done = 1'b1;
          ev_set[`SIE_ST_CALL] = 1'b1;
        end
        sie_pkg::SIE_WAIT_EV:
          if (s_q.ev)
          begin
            s_d.ev   = 1'b0;
            s_d.done = 1'b1;
          end
          else
            s_d.slp = sie_pkg::SIE_SLP_EV;
        sie_pkg::SIE_WAIT_INT: s_d.slp = sie_pkg::SIE_SLP_INT;
      endcase
    end
    // Sleep exit
    if (((s_q.slp == sie_pkg::SIE_SLP_EV) && wake_ev) ||
        ((s_q.slp == sie_pkg::SIE_SLP_INT) && wake_int))
    begin
      s_d.slp  = sie_pkg::SIE_RUN;
      s_d.done = 1'b1;
      ev_set[`SIE_ST_WAKE] = 1'b1;
    end
    // Busy flag registered so the output comes from a flop
    s_d.busy = (s_d.slp != sie_pkg::SIE_RUN);
    // Event bit: an external event not consumed by a wake is kept, set wins
    if ((iss && op_kind == sie_pkg::SIE_SEND_EV) ||
        (ext_ev && s_q.slp != sie_pkg::SIE_SLP_EV))
      s_d.ev = 1'b1;
    // Register writes, status cleared by writing one, set wins
    s_d.stat = s_q.stat;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `SIE_OFF_STAT: s_d.stat = s_q.stat & ~reg_wdata[3:0];
        `SIE_OFF_MASK: s_d.mask = reg_wdata[3:0];
        `SIE_OFF_CTRL:
        begin
          s_d.pend_wake = reg_wdata[`SIE_CT_SOP];
          s_d.dbg_en    = reg_wdata[`SIE_CT_DBG];
        end
        default: s_d.mask = s_q.mask;
      endcase
    end
    s_d.stat = s_d.stat | ev_set[3:0];
    s_d.irq  = |(s_d.stat & s_d.mask);
    // Read data valid the cycle after the strobe only
    s_d.rdata = 32'h00000000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SIE_OFF_STAT: s_d.rdata = {28'h0000000, s_q.stat};
        `SIE_OFF_MASK: s_d.rdata = {28'h0000000, s_q.mask};
        `SIE_OFF_CTRL: s_d.rdata = {29'h00000000, s_q.ev, s_q.dbg_en, s_q.pend_wake};
        default:       s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q         <= '0;
      s_q.slp     <= sie_pkg::SIE_RUN;
      s_q.mask    <= `SIE_MASK_RST;
      s_q.pri_thr <= `SIE_PRIO_RST;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from the state flops
  assign reg_rdata     = s_q.rdata;
  assign irq           = s_q.irq;
  assign op_done       = s_q.done;
  assign op_busy       = s_q.busy;
  assign pipe_flush    = s_q.flush;
  assign call_exc      = s_q.call;
  assign send_ev_out   = s_q.sevo;
  assign rd_spec_data  = s_q.rd_val;
  assign flags_out     = s_q.flags;
  assign pri_thr_out   = s_q.pri_thr[PRIO_W-1:0];
  assign glb_mask_out  = s_q.glb_mask;
  assign flt_mask_out  = s_q.flt_mask;
  assign control_out   = s_q.control;
  assign event_reg_out = s_q.ev;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_isb_flush;
    iss && op_kind == sie_pkg::SIE_SYNC_BAR |=> pipe_flush && op_done ##1
      (!pipe_flush || $past(iss && op_kind == sie_pkg::SIE_SYNC_BAR));
  endproperty
  a_isb_flush: assert property (p_isb_flush) else $error("barrier did not flush");

  property p_alias_read;
    iss && op_kind == sie_pkg::SIE_RD_SPEC && spec_sel == sie_pkg::SIE_PRI_RAISE
      |=> rd_spec_data[PRIO_W-1:0] == $past(pri_thr_out);
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("alias read mismatch");

  property p_unpriv;
    iss && op_kind == sie_pkg::SIE_WR_SPEC && !privileged
      |=> $stable(glb_mask_out) && $stable(flt_mask_out) && $stable(control_out);
  endproperty
  a_unpriv: assert property (p_unpriv) else $error("unprivileged write reached mask");

  property p_raise;
    iss && op_kind == sie_pkg::SIE_WR_SPEC && privileged &&
      spec_sel == sie_pkg::SIE_PRI_RAISE && (src_pri == '0 ||
      (pri_thr_out != '0 && src_pri >= pri_thr_out)) |=> $stable(pri_thr_out);
  endproperty
  a_raise: assert property (p_raise) else $error("raise alias lowered threshold");

  property p_flags;
    iss && op_kind == sie_pkg::SIE_WR_SPEC && app_ok |=> flags_out == $past(src_val[31:27]);
  endproperty
  a_flags: assert property (p_flags) else $error("flags not taken from source");

  property p_sev;
    iss && op_kind == sie_pkg::SIE_SEND_EV |=> send_ev_out && event_reg_out;
  endproperty
  a_sev: assert property (p_sev) else $error("send event lost");

  property p_svc;
    iss && op_kind == sie_pkg::SIE_SUP_CALL |=> call_exc ##1
      (!call_exc || $past(iss && op_kind == sie_pkg::SIE_SUP_CALL));
  endproperty
  a_svc: assert property (p_svc) else $error("supervisor call not raised");

  property p_wfe_sleep;
    iss && op_kind == sie_pkg::SIE_WAIT_EV && !event_reg_out |=> op_busy && !op_done;
  endproperty
  a_wfe_sleep: assert property (p_wfe_sleep) else $error("event wait did not sleep");

  property p_wfe_dbg;
    s_q.slp == sie_pkg::SIE_SLP_EV && s_q.dbg_s2 && s_q.dbg_en |=> !op_busy && op_done;
  endproperty
  a_wfe_dbg: assert property (p_wfe_dbg) else $error("debug did not wake event wait");

  property p_wfe_pass;
    iss && op_kind == sie_pkg::SIE_WAIT_EV && event_reg_out && !ext_ev
      |=> op_done && !op_busy && !event_reg_out;
  endproperty
  a_wfe_pass: assert property (p_wfe_pass) else $error("event wait did not pass");

  property p_wfi_wake;
    s_q.slp == sie_pkg::SIE_SLP_INT && s_q.dbg_s2 |=> op_done && !op_busy;
  endproperty
  a_wfi_wake: assert property (p_wfi_wake) else $error("debug did not wake");

  property p_keep_flags;
    !(iss && op_kind == sie_pkg::SIE_WR_SPEC) |=> $stable(flags_out);
  endproperty
  a_keep_flags: assert property (p_keep_flags) else $error("flags changed");

  c_wfe_sleep: cover property (iss && op_kind == sie_pkg::SIE_WAIT_EV ##[1:20] op_done);
  c_wfi_exc:   cover property (op_busy && exc_take ##1 op_done);
  c_raise:     cover property (iss && spec_sel == sie_pkg::SIE_PRI_RAISE ##1
                               $changed(pri_thr_out));
  c_irq:       cover property ($rose(irq));
endmodule
`default_nettype wire

// [src/sie_params.svh]
// Offsets, field positions and reset values of the system instruction executor
`ifndef SIE_PARAMS_SVH
`define SIE_PARAMS_SVH
// Register offsets (byte addresses)
`define SIE_OFF_STAT  4'h0
`define SIE_OFF_MASK  4'h4
`define SIE_OFF_CTRL  4'h8
// Status and mask bit positions
`define SIE_ST_CALL   0
`define SIE_ST_SEND   1
`define SIE_ST_FLUSH  2
`define SIE_ST_WAKE   3
`define SIE_ST_W      4
// Control bit positions
`define SIE_CT_SOP    0
`define SIE_CT_DBG    1
`define SIE_CT_EV     2
// Condition flag field inside the status words
`define SIE_FLAG_LSB  27
`define SIE_FLAG_W    5
// Reset values
`define SIE_MASK_RST  4'h0
`define SIE_PRIO_RST  8'h00
`endif

// [src/sie_pkg.sv]
// Types of the system instruction executor
package sie_pkg;
  // Instruction kinds handed over by decode
  typedef enum logic [2:0] {
    SIE_SYNC_BAR, SIE_RD_SPEC, SIE_WR_SPEC, SIE_NO_OP, SIE_SEND_EV, SIE_SUP_CALL,
    SIE_WAIT_EV, SIE_WAIT_INT
  } sie_op_t;
  // Special register selector
  typedef enum logic [3:0] {
    SIE_APP_SW, SIE_IPSR, SIE_EPSR, SIE_IEPSR, SIE_IAPSR, SIE_EAPSR, SIE_ALL_SW,
    SIE_MSP, SIE_PSP, SIE_GLB_MASK, SIE_PRI_THR, SIE_PRI_RAISE, SIE_FLT_MASK,
    SIE_CONTROL
  } sie_spec_t;
  // Sleep state
  typedef enum logic [1:0] {SIE_RUN, SIE_SLP_EV, SIE_SLP_INT} sie_slp_t;
  // Whole state of the executor
  typedef struct packed {
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic        dbg_s1;
    logic        dbg_s2;
    logic        ev;
    sie_slp_t    slp;
    logic        busy;
    logic        done;
    logic        flush;
    logic        call;
    logic        sevo;
    logic [31:0] rd_val;
    logic [4:0]  flags;
    logic [7:0]  pri_thr;
    logic        glb_mask;
    logic        flt_mask;
    logic [1:0]  control;
    logic        pend_wake;
    logic        dbg_en;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [31:0] rdata;
    logic        irq;
  } sie_state_t;
endpackage
